// ==== hdl/emwc_pkg.sv ====
// shared constants and types for the external memory wait configuration
package emwc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EMWC_SEG_CFG_OFF   = 8'hf6;
  localparam logic [7:0] EMWC_SEG_CFG_PAGE  = 8'h15;
  localparam logic [7:0] EMWC_SEG_CFG_RST   = 8'h1f;
  localparam logic [7:0] EMWC_WAIT_CTL_OFF  = 8'hfc;
  localparam logic [7:0] EMWC_WAIT_CTL_PAGE = 8'h00;
  localparam logic [7:0] EMWC_WAIT_CTL_RST  = 8'h7f;
  localparam logic [7:0] EMWC_RSVD_MASK     = 8'h7f;

  // data page registers and the port data registers they swap with
  localparam logic [7:0] EMWC_DPR_PAGE      = 8'h15;
  localparam logic [7:0] EMWC_DPR_BASE      = 8'hf0;
  localparam logic [7:0] EMWC_PORT_DR_BASE  = 8'he0;
  localparam logic [7:0] EMWC_QUAD_MASK     = 8'hfc;

  // internal address width and the block select bit
  localparam int EMWC_ADDR_W    = 22;
  localparam int EMWC_BLOCK_BIT = 21;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       reserved;
    logic       code_segment_save_enable;
    logic       page_register_remap;
    logic       memory_select_bit;
    logic [1:0] lower_addr_strobe_wait;
    logic [1:0] upper_addr_strobe_wait;
  } emwc_seg_cfg_t;

  typedef struct packed {
    logic       reserved;
    logic       watchdog_enable_bit;
    logic [2:0] upper_data_strobe_wait;
    logic [2:0] lower_data_strobe_wait;
  } emwc_wait_ctl_t;

  // per-access settings captured by the sequencer
  typedef struct packed {
    logic       upper;
    logic [1:0] as_wait;
    logic [2:0] ds_wait;
    logic       ds2_en;
    logic       wait_en;
  } emwc_acc_cfg_t;

  typedef enum {EMWC_IDLE, EMWC_ADDR, EMWC_DATA} emwc_seq_state_t;

endpackage : emwc_pkg

// ==== hdl/emwc_seq.sv ====
// access sequencer: address phase, data phase and wait stretching
`timescale 1ns/1ns
module emwc_seq
  import emwc_pkg::*;
(
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // request
  input  wire logic          acc_start,
  input  wire emwc_acc_cfg_t acc_cfg,
  input  wire logic          wait_low,
  // strobes and status
  output logic               address_strobe_n,
  output logic               data_strobe_n,
  output logic               second_data_strobe_n,
  output logic               acc_busy,
  output logic               acc_done
);

  emwc_seq_state_t state_ff, nxt_state;
  emwc_acc_cfg_t   cfg_ff,   nxt_cfg;
  logic [2:0]      cnt_ff,   nxt_cnt;
  logic            as_n_ff,  nxt_as_n;
  logic            ds_n_ff,  nxt_ds_n;
  logic            ds2_n_ff, nxt_ds2_n;
  logic            done_ff,  nxt_done;
  logic            lower_ds2;
  logic            held;

  // ----------------------------------------------------------------
  // next state: programmed count runs out first, then the wait pin
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cfg   = cfg_ff;
    nxt_cnt   = cnt_ff;
    nxt_done  = 1'b0;
    held      = cfg_ff.wait_en && wait_low; // see R17
    case (state_ff)
      EMWC_IDLE: begin
        if (acc_start) begin
          nxt_state = EMWC_ADDR;
          nxt_cfg   = acc_cfg;
          nxt_cnt   = {1'b0, acc_cfg.as_wait}; // see R6 see R7
        end
      end
      EMWC_ADDR: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 3'h1; // see R18
        end else if (!held) begin
          nxt_state = EMWC_DATA;
          nxt_cnt   = cfg_ff.ds_wait; // see R11 see R12 see R13
        end
      end
      EMWC_DATA: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 3'h1; // see R18
        end else if (!held) begin
          nxt_state = EMWC_IDLE;
          nxt_done  = 1'b1;
        end
      end
      default: nxt_state = EMWC_IDLE;
    endcase
    // lower block with the second strobe on keeps the primary high
    lower_ds2 = !nxt_cfg.upper && nxt_cfg.ds2_en; // see R14 see R16
    nxt_as_n  = (nxt_state != EMWC_ADDR);
    nxt_ds_n  = !((nxt_state == EMWC_DATA) && !lower_ds2);
    nxt_ds2_n = !((nxt_state == EMWC_DATA) && lower_ds2);
  end

  // strobes come from flops so they never glitch on the pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= EMWC_IDLE;
      cfg_ff   <= '0;
      cnt_ff   <= '0;
      as_n_ff  <= 1'b1;
      ds_n_ff  <= 1'b1;
      ds2_n_ff <= 1'b1;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cfg_ff   <= nxt_cfg;
      cnt_ff   <= nxt_cnt;
      as_n_ff  <= nxt_as_n;
      ds_n_ff  <= nxt_ds_n;
      ds2_n_ff <= nxt_ds2_n;
      done_ff  <= nxt_done;
    end
  end

  assign address_strobe_n     = as_n_ff;
  assign data_strobe_n        = ds_n_ff;
  assign second_data_strobe_n = ds2_n_ff;
  assign acc_busy             = (state_ff != EMWC_IDLE);
  assign acc_done             = done_ff;

endmodule : emwc_seq

// ==== hdl/emwc_top.sv ====
// external memory configuration registers and wait-state control
//
// Overview of operation
// R1: segment config register resets to 1Fh
// R2: save off: interrupt segment used, push pc/flags
// R3: save on: push code segment, load, restore
// R4: remap bit swaps page registers with port data
// R5: software keeps memory select bit at one
// R6: lower block stretches address strobe 0..3
// R7: upper block stretches address strobe 0..3
// R8: segment config writes ignored during interrupt service
// R9: wait control resets 7Fh, top bit reads zero
// R10: clearing watchdog enable selects watchdog mode
// R11: upper block data strobe stretch 0..7
// R12: lower block active strobe stretch 0..7
// R13: data stretch counts internal clock cycles
// R14: primary strobe upper, second strobe lower
// R15: software may zero data stretch for speed
// R16: second strobe active, primary held high
// R17: sampled wait adds one cycle, resampled
// R18: programmed stretch precedes wait pin stretch
`timescale 1ns/1ns
module emwc_top
  import emwc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // register file access
  input  wire logic [7:0]             reg_page,
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_wdata,
  output logic [7:0]                  reg_rdata,
  // page register decode
  output logic                        dpr_hit,
  output logic [1:0]                  dpr_index,
  output logic                        port_dr_hit,
  // configuration levels
  output logic                        page_register_remap,
  output logic                        memory_select_bit,
  output logic                        watchdog_mode,
  // interrupt entry and return
  input  wire logic                   int_entry,
  input  wire logic                   int_return,
  input  wire logic                   in_service,
  output logic                        use_isr_segment,
  output logic                        push_pc_flags,
  output logic                        push_code_segment,
  output logic                        load_cs_from_isr,
  output logic                        restore_code_segment,
  // external access
  input  wire logic                   acc_start,
  input  wire logic [EMWC_ADDR_W-1:0] acc_addr,
  input  wire logic                   second_strobe_enable,
  input  wire logic                   wait_enable,
  input  wire logic                   wait_n_pin,
  output logic                        acc_busy,
  output logic                        acc_done,
  output logic                        address_strobe_n,
  output logic                        data_strobe_n,
  output logic                        second_data_strobe_n
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] pg,
                                   input logic [7:0] ad,
                                   input logic [7:0] want_pg,
                                   input logic [7:0] want_ad);
    reg_hit = (pg == want_pg) && (ad == want_ad);
  endfunction : reg_hit

  // four consecutive registers starting at an aligned base
  function automatic logic quad_hit(input logic [7:0] ad,
                                    input logic [7:0] base);
    quad_hit = ((ad & EMWC_QUAD_MASK) == base);
  endfunction : quad_hit

  emwc_seg_cfg_t  seg_cfg_ff,  nxt_seg_cfg;
  emwc_wait_ctl_t wait_ctl_ff, nxt_wait_ctl;
  logic [7:0]     rdata_ff,    nxt_rdata;
  logic           seg_sel, wait_sel;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    seg_sel  = reg_hit(reg_page, reg_addr,
                       EMWC_SEG_CFG_PAGE, EMWC_SEG_CFG_OFF);
    wait_sel = reg_hit(reg_page, reg_addr,
                       EMWC_WAIT_CTL_PAGE, EMWC_WAIT_CTL_OFF);
    nxt_seg_cfg  = seg_cfg_ff;
    nxt_wait_ctl = wait_ctl_ff;
    nxt_rdata    = rdata_ff;
    // writes are dropped during service so the segment mode cannot
    // change under a routine that is already running
    if (reg_wr && seg_sel && !in_service) begin // see R8
      nxt_seg_cfg = emwc_seg_cfg_t'(reg_wdata & EMWC_RSVD_MASK);
    end
    if (reg_wr && wait_sel) begin
      nxt_wait_ctl = emwc_wait_ctl_t'(reg_wdata & EMWC_RSVD_MASK); // see R9
    end
    if (reg_rd) begin
      if (seg_sel) begin
        nxt_rdata = seg_cfg_ff & EMWC_RSVD_MASK;
      end else if (wait_sel) begin
        nxt_rdata = wait_ctl_ff & EMWC_RSVD_MASK; // see R9
      end else begin
        nxt_rdata = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seg_cfg_ff  <= EMWC_SEG_CFG_RST;  // see R1
      wait_ctl_ff <= EMWC_WAIT_CTL_RST; // see R9
      rdata_ff    <= '0;
    end else begin
      seg_cfg_ff  <= nxt_seg_cfg;
      wait_ctl_ff <= nxt_wait_ctl;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign reg_rdata           = rdata_ff;
  assign page_register_remap = seg_cfg_ff.page_register_remap;
  // the select bit is only reflected; software must keep it set
  assign memory_select_bit   = seg_cfg_ff.memory_select_bit; // see R5
  assign watchdog_mode       = !wait_ctl_ff.watchdog_enable_bit; // see R10

  // ----------------------------------------------------------------
  // data page register location
  // ----------------------------------------------------------------
  always_comb begin
    dpr_index   = reg_addr[1:0];
    dpr_hit     = 1'b0;
    port_dr_hit = 1'b0;
    if (!seg_cfg_ff.page_register_remap) begin // see R4
      dpr_hit     = (reg_page == EMWC_DPR_PAGE)
                    && quad_hit(reg_addr, EMWC_DPR_BASE);
      port_dr_hit = quad_hit(reg_addr, EMWC_PORT_DR_BASE);
    end else begin
      dpr_hit     = quad_hit(reg_addr, EMWC_PORT_DR_BASE);
      port_dr_hit = (reg_page == EMWC_DPR_PAGE)
                    && quad_hit(reg_addr, EMWC_DPR_BASE);
    end
  end

  // ----------------------------------------------------------------
  // interrupt segment handling
  // ----------------------------------------------------------------
  logic svc_save_ff,  nxt_svc_save;
  logic use_isr_ff,   nxt_use_isr;
  logic push_pf_ff,   nxt_push_pf;
  logic push_cs_ff,   nxt_push_cs;
  logic load_cs_ff,   nxt_load_cs;
  logic restore_ff,   nxt_restore;

  // the mode is latched at entry so the return matches the frame
  always_comb begin
    nxt_svc_save = svc_save_ff;
    nxt_use_isr  = use_isr_ff;
    nxt_push_pf  = 1'b0;
    nxt_push_cs  = 1'b0;
    nxt_load_cs  = 1'b0;
    nxt_restore  = 1'b0;
    if (int_entry) begin
      nxt_svc_save = seg_cfg_ff.code_segment_save_enable;
      nxt_push_pf  = 1'b1;                                    // see R2
      nxt_use_isr  = !seg_cfg_ff.code_segment_save_enable;    // see R2
      nxt_push_cs  = seg_cfg_ff.code_segment_save_enable;     // see R3
      nxt_load_cs  = seg_cfg_ff.code_segment_save_enable;     // see R3
    end else if (int_return) begin
      nxt_restore  = svc_save_ff;                             // see R3
      nxt_use_isr  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      svc_save_ff <= 1'b0;
      use_isr_ff  <= 1'b0;
      push_pf_ff  <= 1'b0;
      push_cs_ff  <= 1'b0;
      load_cs_ff  <= 1'b0;
      restore_ff  <= 1'b0;
    end else begin
      svc_save_ff <= nxt_svc_save;
      use_isr_ff  <= nxt_use_isr;
      push_pf_ff  <= nxt_push_pf;
      push_cs_ff  <= nxt_push_cs;
      load_cs_ff  <= nxt_load_cs;
      restore_ff  <= nxt_restore;
    end
  end

  assign use_isr_segment      = use_isr_ff;
  assign push_pc_flags        = push_pf_ff;
  assign push_code_segment    = push_cs_ff;
  assign load_cs_from_isr     = load_cs_ff;
  assign restore_code_segment = restore_ff;

  // ----------------------------------------------------------------
  // external access: wait pin sync and sequencer
  // ----------------------------------------------------------------
  logic          wait_s1_ff, wait_s2_ff;
  emwc_acc_cfg_t acc_cfg;

  // two flops; the pin is asynchronous to clk_sys
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_s1_ff <= 1'b1;
      wait_s2_ff <= 1'b1;
    end else begin
      wait_s1_ff <= wait_n_pin;
      wait_s2_ff <= wait_s1_ff;
    end
  end

  // block select is the top internal address bit
  always_comb begin
    acc_cfg.upper   = acc_addr[EMWC_BLOCK_BIT];
    acc_cfg.as_wait = acc_addr[EMWC_BLOCK_BIT]
                      ? seg_cfg_ff.upper_addr_strobe_wait  // see R7
                      : seg_cfg_ff.lower_addr_strobe_wait; // see R6
    acc_cfg.ds_wait = acc_addr[EMWC_BLOCK_BIT]
                      ? wait_ctl_ff.upper_data_strobe_wait  // see R11
                      : wait_ctl_ff.lower_data_strobe_wait; // see R12
    acc_cfg.ds2_en  = second_strobe_enable;
    acc_cfg.wait_en = wait_enable;
  end

  emwc_seq u_seq (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .acc_start            (acc_start),
    .acc_cfg              (acc_cfg),
    .wait_low             (!wait_s2_ff),
    .address_strobe_n     (address_strobe_n),
    .data_strobe_n        (data_strobe_n),
    .second_data_strobe_n (second_data_strobe_n),
    .acc_busy             (acc_busy),
    .acc_done             (acc_done)
  );

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  logic       seg_wr_seen_ff;
  logic [3:0] low_len_ff;
  logic [3:0] exp_as_ff;
  logic [3:0] exp_ds_ff;
  logic       nowait_ff;

  // length of the current strobe-low phase and its expected length
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seg_wr_seen_ff <= 1'b0;
      low_len_ff     <= '0;
      exp_as_ff      <= '0;
      exp_ds_ff      <= '0;
      nowait_ff      <= 1'b0;
    end else begin
      if (reg_wr && seg_sel)
        seg_wr_seen_ff <= 1'b1;
      if (!acc_busy && acc_start) begin
        exp_as_ff <= {2'b00, acc_cfg.as_wait} + 4'h1;
        exp_ds_ff <= {1'b0, acc_cfg.ds_wait} + 4'h1;
        nowait_ff <= !wait_enable;
      end
      if (!address_strobe_n || !data_strobe_n || !second_data_strobe_n)
        low_len_ff <= low_len_ff + 4'h1;
      else
        low_len_ff <= '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_seg_reset;
    !seg_wr_seen_ff |-> (seg_cfg_ff == EMWC_SEG_CFG_RST);
  endproperty
  a_seg_reset: assert property (p_seg_reset) // see R1
    else $error("segment config lost its reset value");

  property p_isr_mode;
    int_entry && !seg_cfg_ff.code_segment_save_enable |=>
      push_pc_flags && !push_code_segment && use_isr_segment;
  endproperty
  a_isr_mode: assert property (p_isr_mode) // see R2
    else $error("interrupt segment mode pushed code segment");

  property p_cs_save;
    int_entry && seg_cfg_ff.code_segment_save_enable |=>
      push_code_segment && load_cs_from_isr && !use_isr_segment;
  endproperty
  a_cs_save: assert property (p_cs_save) // see R3
    else $error("code segment not saved on entry");

  property p_remap;
    page_register_remap && (reg_page == EMWC_DPR_PAGE)
      && quad_hit(reg_addr, EMWC_DPR_BASE) |-> port_dr_hit && !dpr_hit;
  endproperty
  a_remap: assert property (p_remap) // see R4
    else $error("remapped page register still decoded");

  property p_isr_write;
    reg_wr && seg_sel && in_service |=> $stable(seg_cfg_ff);
  endproperty
  a_isr_write: assert property (p_isr_write) // see R8
    else $error("segment config written during service");

  property p_wait_msb;
    reg_rd && wait_sel |=> (reg_rdata[7] == 1'b0);
  endproperty
  a_wait_msb: assert property (p_wait_msb) // see R9
    else $error("wait control top bit read as one");

  property p_wdg;
    reg_wr && wait_sel |=> (watchdog_mode == !$past(reg_wdata[6]));
  endproperty
  a_wdg: assert property (p_wdg) // see R10
    else $error("watchdog mode does not follow the enable bit");

  property p_as_len;
    $rose(address_strobe_n) && nowait_ff |-> low_len_ff == exp_as_ff;
  endproperty
  a_as_len: assert property (p_as_len) // see R6
    else $error("address strobe stretch length wrong");

  // the data strobe falls on the edge the address strobe rises, so the
  // low run at done spans both phases of the access
  property p_ds_len;
    acc_done && nowait_ff |-> low_len_ff == 4'(exp_as_ff + exp_ds_ff);
  endproperty
  a_ds_len: assert property (p_ds_len) // see R11
    else $error("data strobe stretch length wrong");

  property p_one_strobe;
    !second_data_strobe_n |-> data_strobe_n;
  endproperty
  a_one_strobe: assert property (p_one_strobe) // see R16
    else $error("both data strobes active");

  c_upper: cover property (acc_start && !acc_busy
                           && acc_addr[EMWC_BLOCK_BIT]);
  c_lower_ds2: cover property (!second_data_strobe_n);
  c_cs_save: cover property (int_entry
                             && seg_cfg_ff.code_segment_save_enable);
  c_wait: cover property (!data_strobe_n && !wait_s2_ff
                          && wait_enable);

endmodule : emwc_top

// ==== test/emwc_mem_model.sv ====
// external memory model: answers strobes and may hold the wait pin low
`timescale 1ns/1ns
module emwc_mem_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // strobes from the block
  input  wire logic       data_strobe_n,
  input  wire logic       second_data_strobe_n,
  // number of cycles to stall per data phase, 0 = fast memory
  input  wire logic [3:0] stall_len,
  // wait request, active low, weak pull-up when released
  output logic            wait_n_pin
);
  logic [3:0] stall_ff;
  logic [3:0] nxt_stall;
  logic       strb_ff;
  logic       nxt_strb;

  // start a stall on the falling edge of either data strobe
  always_comb begin
    nxt_strb  = data_strobe_n & second_data_strobe_n;
    nxt_stall = (stall_ff != 4'h0) ? stall_ff - 4'h1 : 4'h0;
    if (strb_ff && !nxt_strb) begin
      nxt_stall = stall_len;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stall_ff <= 4'h0;
      strb_ff  <= 1'b1;
    end else begin
      stall_ff <= nxt_stall;
      strb_ff  <= nxt_strb;
    end
  end

  // released pin reads high through the pull-up
  assign wait_n_pin = (stall_ff == 4'h0);
endmodule : emwc_mem_model

// ==== test/ext_mem_wait_config_tb.sv ====
// self-checking bench for the wait configuration block
`timescale 1ns/1ns
module ext_mem_wait_config_tb;
  import emwc_pkg::*;
  logic        clk_sys, rst, reg_wr, reg_rd, int_entry, int_return;
  logic        in_service, acc_start, second_strobe_enable, wait_enable;
  logic        wait_n_pin, acc_busy, acc_done, address_strobe_n;
  logic        data_strobe_n, second_data_strobe_n, dpr_hit, port_dr_hit;
  logic        page_register_remap, memory_select_bit, watchdog_mode;
  logic        use_isr_segment, push_pc_flags, push_code_segment;
  logic        load_cs_from_isr, restore_code_segment;
  logic [7:0]  reg_page, reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  dpr_index;
  logic [3:0]  stall_len;
  logic [21:0] acc_addr;
  int          fails, checks_done, n_as, n_ds, n_ds2;

  emwc_top DUT (.clk_sys, .rst, .reg_page, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .dpr_hit, .dpr_index, .port_dr_hit,
    .page_register_remap, .memory_select_bit, .watchdog_mode, .int_entry,
    .int_return, .in_service, .use_isr_segment, .push_pc_flags,
    .push_code_segment, .load_cs_from_isr, .restore_code_segment,
    .acc_start, .acc_addr, .second_strobe_enable, .wait_enable, .wait_n_pin,
    .acc_busy, .acc_done, .address_strobe_n, .data_strobe_n,
    .second_data_strobe_n);

  emwc_mem_model mem (.clk_sys, .rst, .data_strobe_n, .second_data_strobe_n,
    .stall_len, .wait_n_pin);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle register strobe, driven on the falling edge
  task automatic wr(logic [7:0] pg, logic [7:0] ad, logic [7:0] d);
    @(negedge clk_sys);
    {reg_page, reg_addr, reg_wdata, reg_wr} = {pg, ad, d, 1'b1};
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(string what, logic [7:0] pg, logic [7:0] ad,
                    logic [7:0] exp);
    @(negedge clk_sys);
    {reg_page, reg_addr, reg_rd} = {pg, ad, 1'b1};
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(what, reg_rdata, exp);
  endtask : rd

  // one access; counts low cycles of each strobe until done
  task automatic acc(logic up, logic ds2, logic wen);
    @(negedge clk_sys);
    {acc_start, second_strobe_enable, wait_enable} = {1'b1, ds2, wen};
    acc_addr = {up, 21'h000123};
    @(negedge clk_sys);
    acc_start = 1'b0;
    chk("acc_busy", acc_busy, 8'h01);
    {n_as, n_ds, n_ds2} = {32'd0, 32'd0, 32'd0};
    for (int i = 0; i < 80 && acc_done !== 1'b1; i++) begin
      n_as += int'(!address_strobe_n);
      n_ds += int'(!data_strobe_n);
      n_ds2 += int'(!second_data_strobe_n);
      @(negedge clk_sys);
    end
    chk("acc_done", acc_done, 8'h01);
    chk("acc_idle", acc_busy, 8'h00);
  endtask : acc

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd("seg_cfg", 8'h15, 8'hf6, 8'h1f);
    rd("wait_ctl", 8'h00, 8'hfc, 8'h7f);
    rd("unmapped", 8'h00, 8'h10, 8'h00);
    chk("memory_select_bit", memory_select_bit, 8'h01);
    chk("wdog", watchdog_mode, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_wait_ctl;
    wr(8'h00, 8'hfc, 8'hbf);
    rd("wait_ctl bit7", 8'h00, 8'hfc, 8'h3f);
    chk("wdog on", watchdog_mode, 8'h01);
    wr(8'h00, 8'hfc, 8'hff);
    chk("wdog off", watchdog_mode, 8'h00);
    $display("test wait control done");
  endtask : t_wait_ctl

  task automatic t_remap;
    {reg_page, reg_addr} = {8'h15, 8'hf2};
    #1 chk("dpr hit", {dpr_hit, 5'h0, dpr_index}, 8'h82);
    wr(8'h15, 8'hf6, 8'h3f);
    {reg_page, reg_addr} = {8'h15, 8'he1};
    #1 chk("dpr swapped", dpr_hit, 8'h01);
    {reg_page, reg_addr} = {8'h15, 8'hf1};
    #1 chk("port swapped", port_dr_hit, 8'h01);
    @(negedge clk_sys);
    in_service = 1'b1;
    wr(8'h15, 8'hf6, 8'h16);
    rd("write in service", 8'h15, 8'hf6, 8'h3f);
    in_service = 1'b0;
    wr(8'h15, 8'hf6, 8'h16);
    rd("seg_cfg", 8'h15, 8'hf6, 8'h16);
    chk("remap off", page_register_remap, 8'h00);
    $display("test remap done");
  endtask : t_remap

  task automatic t_irq(logic save);
    wr(8'h15, 8'hf6, {1'b0, save, 6'h16});
    @(negedge clk_sys);
    int_entry = 1'b1;
    @(negedge clk_sys);
    int_entry = 1'b0;
    chk("entry", {push_pc_flags, push_code_segment, load_cs_from_isr,
        use_isr_segment}, {4'h0, 1'b1, save, save, !save});
    @(negedge clk_sys);
    int_return = 1'b1;
    @(negedge clk_sys);
    int_return = 1'b0;
    chk("return", {restore_code_segment, use_isr_segment},
        {6'h0, save, 1'b0});
    $display("test interrupt save=%0d done", save);
  endtask : t_irq

  task automatic t_access;
    // earlier tests moved the segment config off its reset value
    wr(8'h15, 8'hf6, 8'h1f);
    acc(1'b1, 1'b0, 1'b0); // reset stretch counts
    chk("as up rst", 8'(n_as), 8'h04);
    chk("ds up rst", 8'(n_ds), 8'h08);
    wr(8'h15, 8'hf6, 8'h16);
    wr(8'h00, 8'hfc, 8'h68);
    acc(1'b0, 1'b0, 1'b0);
    chk("as low", 8'(n_as), 8'h02);
    chk("ds low", 8'(n_ds), 8'h01);
    chk("ds2 idle", 8'(n_ds2), 8'h00);
    acc(1'b0, 1'b1, 1'b0);
    chk("ds2 low", 8'(n_ds2), 8'h01);
    chk("ds held", 8'(n_ds), 8'h00);
    acc(1'b1, 1'b1, 1'b0);
    chk("ds upper", 8'(n_ds), 8'h06);
    chk("ds2 upper", 8'(n_ds2), 8'h00);
    stall_len = 4'h3;
    acc(1'b1, 1'b0, 1'b1);
    stall_len = 4'h0;
    chk("as no stall", 8'(n_as), 8'h03);
    chk("ds stalled", 8'(n_ds > 6 && n_ds < 10), 8'h01);
    wr(8'h00, 8'hfc, 8'h40);
    acc(1'b0, 1'b0, 1'b0);
    chk("ds fast", 8'(n_ds), 8'h01);
    $display("test access done");
  endtask : t_access

  initial begin
    {rst, reg_wr, reg_rd, int_entry, int_return, in_service} = 6'h20;
    {acc_start, second_strobe_enable, wait_enable} = 3'h0;
    {reg_page, reg_addr, reg_wdata, acc_addr} = '0;
    {fails, checks_done, stall_len} = '0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_wait_ctl();
    t_remap();
    t_irq(1'b0);
    t_irq(1'b1);
    t_access();
    conclude();
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #(20 * 5000);
    fails++;
    conclude();
  end
endmodule : ext_mem_wait_config_tb
